// ==== verilog/pss_pkg.sv ====
//****************************************************************
// Strap loader package
//****************************************************************
`default_nettype none
package pss_pkg;

	// Soft-strap set as latched or as supplied by the loader
	typedef struct packed {
		logic [5:0] ind_en;     // Indicator enable straps
		logic [1:0] ind_fun;    // Indicator function straps
		logic       auto_x;     // Automatic crossover strap
		logic       manual_x;   // Manual crossover strap, 1 = crossed
		logic       autoneg;    // Auto-negotiation strap
		logic       speed;      // Speed strap, 1 = 100 Mbit/s
		logic       duplex;     // Duplex strap, 1 = full
		logic       bp;         // Backpressure strap
		logic       fdfc;       // Full-duplex flow-control strap
	} pss_straps_t;

	// Strap-derived configuration registers as seen by the port logic
	typedef struct packed {
		logic [5:0] ind_en;     // Indicator enable field
		logic [1:0] ind_fun;    // Indicator function field
		logic       xsel;       // Crossover control select, 1 = straps
		logic       sw_auto_x;  // Software automatic crossover enable
		logic       sw_mdix;    // Software crossed wiring select
		logic       an_en;      // Negotiation enable bit
		logic       speed_lsb;  // Speed select low bit
		logic       duplex;     // Duplex select bit
		logic       adv_10hd;   // 10BASE-T half duplex advertisement
		logic       adv_10fd;   // 10BASE-T full duplex advertisement
		logic       adv_asym;   // Asymmetric pause advertisement
		logic [2:0] mode;       // Operating mode field
		logic       bp_en;      // Backpressure enable bit
		logic       tx_pause;   // Transmit pause enable
		logic       rx_pause;   // Receive pause enable
	} pss_regs_t;

	// Resolved crossover state
	typedef struct packed {
		logic auto_en;          // Automatic crossover active
		logic crossed;          // Crossed wiring when not automatic
	} pss_xover_t;

	// Tie-off values of the straps without a pin, and fixed register values
	localparam logic [5:0] IND_EN_TIE   = 6'h3f;
	localparam logic [1:0] IND_FUN_TIE  = 2'h0;
	localparam logic       MANUAL_X_TIE = 1'h0;
	localparam logic       AUTONEG_TIE  = 1'h1;
	localparam logic       SPEED_TIE    = 1'h1;
	localparam logic       DUPLEX_TIE   = 1'h1;
	localparam logic       BP_TIE       = 1'h1;
	localparam logic       FDFC_TIE     = 1'h1;
	localparam logic       XSEL_RST     = 1'h1;
	localparam logic       SW_AUTO_RST  = 1'h1;
	localparam logic       SW_MDIX_RST  = 1'h0;
	localparam logic [2:0] MODE_ALL     = 3'h7;

	// Register offsets
	localparam logic [7:0] IND_CFG_OFS  = 8'h00;
	localparam logic [7:0] HARDWARE_CONFIG_REGISTER_OFS   = 8'h04;
	localparam logic [7:0] SPC_OFS      = 8'h08;
	localparam logic [7:0] BASIC_OFS    = 8'h0c;
	localparam logic [7:0] ADV_OFS      = 8'h10;
	localparam logic [7:0] MODES_OFS    = 8'h14;
	localparam logic [7:0] MFC_OFS      = 8'h18;
	localparam logic [7:0] RST_CTL_OFS  = 8'h1c;

	// Field positions
	localparam int IND_EN_POS   = 0;
	localparam int IND_FUN_POS  = 8;
	localparam int HW_XSTR_POS  = 0;
	localparam int HW_EEP_POS   = 1;
	localparam int SPC_XSEL_POS = 0;
	localparam int SPC_AUTO_POS = 1;
	localparam int SPC_MDIX_POS = 2;
	localparam int SPC_XAUT_POS = 3;
	localparam int SPC_XCRS_POS = 4;
	localparam int BAS_DUP_POS  = 8;
	localparam int BAS_AN_POS   = 12;
	localparam int BAS_SPD_POS  = 13;
	localparam int ADV_10HD_POS = 5;
	localparam int ADV_10FD_POS = 6;
	localparam int ADV_ASYM_POS = 11;
	localparam int MODE_POS     = 5;
	localparam int MFC_RX_POS   = 0;
	localparam int MFC_TX_POS   = 1;
	localparam int MFC_BP_POS   = 2;
	localparam int RST_DIG_POS  = 0;
	localparam int RST_RLD_POS  = 1;
	localparam int RST_PEND_POS = 2;

endpackage
`default_nettype wire

// ==== verilog/pss_strap_loader.sv ====
// Notes on behaviour
// R01 - Indicator enable straps load enable field
// R02 - Indicator function straps load function field
// R03 - Crossover pin strap copied to strap-state bit
// R04 - Strap mode: manual strap picks straight/crossed
// R05 - Autoneg strap loads negotiation enable bit
// R06 - Autoneg strap shapes speed, duplex, advert, mode
// R07 - Speed strap shapes speed, mode, advert
// R08 - Duplex strap shapes duplex, mode, full advert
// R09 - Backpressure strap loads backpressure enable
// R10 - Flow strap loads transmit and receive pause
// R11 - Flow strap shapes asymmetric pause advert
// R12 - Latch at reset release; loader overrides
// R13 - Digital reset without loader restores latched
// R14 - Defaults hold until written; latch untouched
`timescale 1ns/1ps
`default_nettype none
module pss_strap_loader (
	// Clock and reset
	input  wire logic                 CORE_CLK,
	input  wire logic                 RST_N,
	// Strap pin
	input  wire logic                 P1_CROSSOVER_INDICATOR_PIN,
	// Loader override path
	input  wire logic                 EEP_PRESENT,
	input  wire logic                 EEP_OVR_VALID,
	input  wire pss_pkg::pss_straps_t EEP_OVR_STRAPS,
	// APB slave
	input  wire logic                 PSEL,
	input  wire logic                 PENABLE,
	input  wire logic                 PWRITE,
	input  wire logic [7:0]           PADDR,
	input  wire logic [31:0]          PWDATA,
	output var  logic [31:0]          PRDATA,
	output var  logic                 PREADY,
	output var  logic                 PSLVERR,
	// Configuration to the port logic
	output var  pss_pkg::pss_regs_t   P1_CFG,
	output var  pss_pkg::pss_xover_t  P1_XOVER
);

	//****************************************************************
	// State
	//****************************************************************

	// All state of the block
	typedef struct packed {
		pss_pkg::pss_straps_t latched;  // Straps caught at reset release
		pss_pkg::pss_straps_t active;   // Straps in force (latched or loader)
		pss_pkg::pss_regs_t   regs;     // Strap-derived registers
		pss_pkg::pss_xover_t  xover;    // Resolved crossover
		logic                 eep_used; // Loader values in force
		logic                 pend;     // Waiting for loader after reload
		logic                 pready;   // APB ready
		logic                 pslverr;  // APB error
		logic [31:0]          prdata;   // APB read data
	} pss_state_t;

	pss_state_t st_r;    // Registered state
	pss_state_t st_nxt;  // Next state

	// Straps as seen on the pin and tie-offs
	pss_pkg::pss_straps_t pin_straps;
	// Load defaults this cycle
	logic                 apply;
	// APB access completes this cycle
	logic                 acc_done;
	// APB write completes this cycle
	logic                 wr_done;
	// Address decoded to a register
	logic                 hit;
	// Read data assembled for the address
	logic [31:0]          rd_word;

	//****************************************************************
	// Default derivation
	//****************************************************************

	// Map a strap set onto the register defaults
	function automatic pss_pkg::pss_regs_t strap_defaults(input pss_pkg::pss_straps_t s);
		pss_pkg::pss_regs_t r;
		r           = '0;
		r.ind_en    = s.ind_en;                                      // R01
		r.ind_fun   = s.ind_fun;                                     // R02
		r.xsel      = pss_pkg::XSEL_RST;
		r.sw_auto_x = pss_pkg::SW_AUTO_RST;
		r.sw_mdix   = pss_pkg::SW_MDIX_RST;
		r.an_en     = s.autoneg;                                     // R05
		// Negotiation forces the top speed and full duplex
		r.speed_lsb = s.autoneg | s.speed;                           // R06 R07
		r.duplex    = s.autoneg | s.duplex;                          // R06 R08
		// Fixed 10 Mbit/s advertises half duplex, and full duplex too when the duplex strap is set
		r.adv_10hd  = s.autoneg | ~s.speed;                          // R06 R07
		r.adv_10fd  = s.autoneg | (~s.speed & s.duplex);             // R06 R07 R08
		r.adv_asym  = s.fdfc;                                        // R11
		r.mode      = s.autoneg ? pss_pkg::MODE_ALL : {1'h0, s.speed, s.duplex}; // R06 R07 R08
		r.bp_en     = s.bp;                                          // R09
		r.tx_pause  = s.fdfc;                                        // R10
		r.rx_pause  = s.fdfc;                                        // R10
		return r;
	endfunction

	// Pin strap and tie-offs
	always_comb begin
		pin_straps          = '0;
		pin_straps.ind_en   = pss_pkg::IND_EN_TIE;
		pin_straps.ind_fun  = pss_pkg::IND_FUN_TIE;
		pin_straps.auto_x   = P1_CROSSOVER_INDICATOR_PIN;           // R03
		pin_straps.manual_x = pss_pkg::MANUAL_X_TIE;
		pin_straps.autoneg  = pss_pkg::AUTONEG_TIE;
		pin_straps.speed    = pss_pkg::SPEED_TIE;
		pin_straps.duplex   = pss_pkg::DUPLEX_TIE;
		pin_straps.bp       = pss_pkg::BP_TIE;
		pin_straps.fdfc     = pss_pkg::FDFC_TIE;
	end

	//****************************************************************
	// Read mux
	//****************************************************************

	// Assemble the word at the addressed register
	always_comb begin
		rd_word = '0;
		hit     = 1'h1;
		case (PADDR)
			pss_pkg::IND_CFG_OFS: begin
				rd_word[pss_pkg::IND_EN_POS +: 6]  = st_r.regs.ind_en;
				rd_word[pss_pkg::IND_FUN_POS +: 2] = st_r.regs.ind_fun;
			end
			pss_pkg::HARDWARE_CONFIG_REGISTER_OFS: begin
				rd_word[pss_pkg::HW_XSTR_POS] = st_r.active.auto_x;     // R03
				rd_word[pss_pkg::HW_EEP_POS]  = st_r.eep_used;
			end
			pss_pkg::SPC_OFS: begin
				rd_word[pss_pkg::SPC_XSEL_POS] = st_r.regs.xsel;
				rd_word[pss_pkg::SPC_AUTO_POS] = st_r.regs.sw_auto_x;
				rd_word[pss_pkg::SPC_MDIX_POS] = st_r.regs.sw_mdix;
				rd_word[pss_pkg::SPC_XAUT_POS] = st_r.xover.auto_en;
				rd_word[pss_pkg::SPC_XCRS_POS] = st_r.xover.crossed;
			end
			pss_pkg::BASIC_OFS: begin
				rd_word[pss_pkg::BAS_DUP_POS] = st_r.regs.duplex;
				rd_word[pss_pkg::BAS_AN_POS]  = st_r.regs.an_en;
				rd_word[pss_pkg::BAS_SPD_POS] = st_r.regs.speed_lsb;
			end
			pss_pkg::ADV_OFS: begin
				rd_word[pss_pkg::ADV_10HD_POS] = st_r.regs.adv_10hd;
				rd_word[pss_pkg::ADV_10FD_POS] = st_r.regs.adv_10fd;
				rd_word[pss_pkg::ADV_ASYM_POS] = st_r.regs.adv_asym;
			end
			pss_pkg::MODES_OFS: begin
				rd_word[pss_pkg::MODE_POS +: 3] = st_r.regs.mode;
			end
			pss_pkg::MFC_OFS: begin
				rd_word[pss_pkg::MFC_RX_POS] = st_r.regs.rx_pause;
				rd_word[pss_pkg::MFC_TX_POS] = st_r.regs.tx_pause;
				rd_word[pss_pkg::MFC_BP_POS] = st_r.regs.bp_en;
			end
			pss_pkg::RST_CTL_OFS: begin
				rd_word[pss_pkg::RST_PEND_POS] = st_r.pend;
			end
			// Unmapped address answers with an error
			default: begin
				hit = 1'h0;
			end
		endcase
	end

	//****************************************************************
	// Next state
	//****************************************************************

	// APB handshake terms
	assign acc_done = PSEL & PENABLE & st_r.pready;
	assign wr_done  = acc_done & PWRITE & hit;

	// Compute the next state
	always_comb begin
		st_nxt = st_r;
		apply  = 1'h0;
		// Bus answer: ready one cycle into the access phase
		st_nxt.pready  = PSEL & PENABLE & ~st_r.pready;
		st_nxt.pslverr = PSEL & PENABLE & ~st_r.pready & ~hit;
		if (PSEL & PENABLE & ~st_r.pready) begin
			st_nxt.prdata = PWRITE ? 32'h0 : rd_word;
		end
		// Software writes change registers, never the latch
		if (wr_done) begin                                           // R14
			unique case (PADDR)
				pss_pkg::IND_CFG_OFS: begin
					st_nxt.regs.ind_en  = PWDATA[pss_pkg::IND_EN_POS +: 6];
					st_nxt.regs.ind_fun = PWDATA[pss_pkg::IND_FUN_POS +: 2];
				end
				pss_pkg::SPC_OFS: begin
					st_nxt.regs.xsel      = PWDATA[pss_pkg::SPC_XSEL_POS];
					st_nxt.regs.sw_auto_x = PWDATA[pss_pkg::SPC_AUTO_POS];
					st_nxt.regs.sw_mdix   = PWDATA[pss_pkg::SPC_MDIX_POS];
				end
				pss_pkg::BASIC_OFS: begin
					st_nxt.regs.duplex    = PWDATA[pss_pkg::BAS_DUP_POS];
					st_nxt.regs.an_en     = PWDATA[pss_pkg::BAS_AN_POS];
					st_nxt.regs.speed_lsb = PWDATA[pss_pkg::BAS_SPD_POS];
				end
				pss_pkg::ADV_OFS: begin
					st_nxt.regs.adv_10hd = PWDATA[pss_pkg::ADV_10HD_POS];
					st_nxt.regs.adv_10fd = PWDATA[pss_pkg::ADV_10FD_POS];
					st_nxt.regs.adv_asym = PWDATA[pss_pkg::ADV_ASYM_POS];
				end
				pss_pkg::MODES_OFS: begin
					st_nxt.regs.mode = PWDATA[pss_pkg::MODE_POS +: 3];
				end
				pss_pkg::MFC_OFS: begin
					st_nxt.regs.rx_pause = PWDATA[pss_pkg::MFC_RX_POS];
					st_nxt.regs.tx_pause = PWDATA[pss_pkg::MFC_TX_POS];
					st_nxt.regs.bp_en    = PWDATA[pss_pkg::MFC_BP_POS];
				end
				pss_pkg::RST_CTL_OFS: begin
					// Digital reset or reload: pins are not sampled again
					if (PWDATA[pss_pkg::RST_DIG_POS] | PWDATA[pss_pkg::RST_RLD_POS]) begin
						if (EEP_PRESENT) begin
							st_nxt.pend = 1'h1;
						end else begin
							st_nxt.active   = st_r.latched;              // R13
							st_nxt.eep_used = 1'h0;
							apply           = 1'h1;
						end
					end
				end
				// Strap-state register is read-only
				pss_pkg::HARDWARE_CONFIG_REGISTER_OFS: begin
				end
			endcase
		end
		// Loader values override the straps and win over a write
		if (EEP_OVR_VALID) begin                                     // R12
			st_nxt.active   = EEP_OVR_STRAPS;
			st_nxt.eep_used = 1'h1;
			st_nxt.pend     = 1'h0;
			apply           = 1'h1;
		end
		// Reload the strap-derived registers
		if (apply) begin
			st_nxt.regs = strap_defaults(st_nxt.active);
		end
		// Resolve crossover from straps or software
		if (st_r.regs.xsel) begin
			st_nxt.xover.auto_en = st_r.active.auto_x;                   // R04
			st_nxt.xover.crossed = ~st_r.active.auto_x & st_r.active.manual_x; // R04
		end else begin
			st_nxt.xover.auto_en = st_r.regs.sw_auto_x;
			st_nxt.xover.crossed = ~st_r.regs.sw_auto_x & st_r.regs.sw_mdix;
		end
		// Pin reset: catch the straps until release
		if (!RST_N) begin
			st_nxt          = '0;
			st_nxt.latched  = pin_straps;                                // R12
			st_nxt.active   = pin_straps;
			st_nxt.regs     = strap_defaults(pin_straps);                // R01 R02 R05 R09 R10
		end
	end

	//****************************************************************
	// Registers
	//****************************************************************

	// Register the state
	always_ff @(posedge CORE_CLK) begin
		st_r <= st_nxt;
	end

	// Outputs straight from the state flip-flops
	assign PRDATA   = st_r.prdata;
	assign PREADY   = st_r.pready;
	assign PSLVERR  = st_r.pslverr;
	assign P1_CFG   = st_r.regs;
	assign P1_XOVER = st_r.xover;

	//****************************************************************
	// Checks
	//****************************************************************

	// Strap pin caught at reset release
	strap_latch_a: assert property (@(posedge CORE_CLK) // R03
		$rose(RST_N) |-> st_r.latched.auto_x == $past(P1_CROSSOVER_INDICATOR_PIN))
		else $error("crossover strap not latched at release");

	// Latch never moves outside pin reset
	latch_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R14
		$past(RST_N) |-> $stable(st_r.latched))
		else $error("latched straps changed after reset");

	// Indicator fields come up from their tie-offs
	ind_default_a: assert property (@(posedge CORE_CLK) // R01
		$rose(RST_N) |-> st_r.regs.ind_en == pss_pkg::IND_EN_TIE
			&& st_r.regs.ind_fun == pss_pkg::IND_FUN_TIE)
		else $error("indicator defaults wrong after reset");

	// Function field default stays until a write or load
	fun_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R02
		!wr_done && !apply && $past(RST_N) |=> $stable(st_r.regs.ind_fun))
		else $error("indicator function changed without cause");

	// Negotiation, duplex and mode follow the straps on load
	phy_default_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R05
		apply |=> st_r.regs.an_en == st_r.active.autoneg
			&& st_r.regs.mode == (st_r.active.autoneg ? pss_pkg::MODE_ALL
				: {1'h0, st_r.active.speed, st_r.active.duplex})
			&& st_r.regs.duplex == (st_r.active.autoneg | st_r.active.duplex))
		else $error("phy defaults do not follow straps");

	// Flow control bits follow their straps on load
	flow_default_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R10
		apply |=> st_r.regs.tx_pause == st_r.active.fdfc
			&& st_r.regs.rx_pause == st_r.active.fdfc
			&& st_r.regs.bp_en == st_r.active.bp
			&& st_r.regs.adv_asym == st_r.active.fdfc)
		else $error("flow control defaults do not follow straps");

	// Digital reset with no loader restores latched straps
	restore_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R13
		wr_done && PADDR == pss_pkg::RST_CTL_OFS && PWDATA[pss_pkg::RST_DIG_POS]
			&& !EEP_PRESENT && !EEP_OVR_VALID
			|=> st_r.active == st_r.latched && !st_r.eep_used)
		else $error("latched straps not restored");

	// Strap-mode crossover follows the manual strap
	xover_strap_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R04
		st_r.regs.xsel && !st_r.active.auto_x ##1 $stable(st_r.active)
			|-> !st_r.xover.auto_en && st_r.xover.crossed == st_r.active.manual_x)
		else $error("crossover not taken from straps");

	// Loader override lands in the active straps
	override_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R12
		EEP_OVR_VALID |=> st_r.active == $past(EEP_OVR_STRAPS) && st_r.eep_used)
		else $error("loader override lost");

	// Every access phase is answered in the next cycle
	apb_answer_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
		else $error("apb answer not in one cycle");

	// Main scenarios
	cov_override_c: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
		EEP_OVR_VALID ##1 st_r.eep_used);
	cov_restore_c: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
		st_r.eep_used ##[1:20] !st_r.eep_used);
	cov_write_c: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
		wr_done && PADDR == pss_pkg::BASIC_OFS);
	cov_error_c: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
		PREADY && PSLVERR);

endmodule
`default_nettype wire

// ==== verif/pss_strap_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pss_strap_model (
	// Clock
	input  wire logic                 clk,
	// Reset and strap pin
	output var  logic                 rst_n,
	output var  logic                 pin,
	// Loader side
	output var  logic                 eep_present,
	output var  logic                 eep_valid,
	output var  pss_pkg::pss_straps_t eep_straps
);
	//****************************************************************
	// Pin reset and loader model
	//****************************************************************

	// Power-on state: reset asserted, strap pin at its pull level
	initial begin
		rst_n       = 1'h0;
		pin         = 1'h1;
		eep_present = 1'h0;
		eep_valid   = 1'h0;
		eep_straps  = '0;
	end

	// Pin reset: strap level set while reset is low, then released
	task automatic pin_reset(input logic level, input int cycles);
		@(posedge clk);
		rst_n <= 1'h0;
		pin   <= level;
		repeat (cycles) @(posedge clk);
		rst_n <= 1'h1;
	endtask

	// Strap pin and loader presence change after the latch
	task automatic set_lines(input logic level, input logic present);
		@(posedge clk);
		pin         <= level;
		eep_present <= present;
	endtask

	// Loader delivery: one-cycle pulse, payload scrambled afterwards
	task automatic load(input pss_pkg::pss_straps_t s);
		@(posedge clk);
		eep_valid  <= 1'h1;
		eep_straps <= s;
		@(posedge clk);
		eep_valid  <= 1'h0;
		eep_straps <= ~s;
	endtask
endmodule
`default_nettype wire

// ==== verif/tb_port1_led_strap_defaults.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_port1_led_strap_defaults;
	//****************************************************************
	// Signals
	//****************************************************************
	logic                 clk;          // Core clock
	logic                 rst_n;        // Pin reset from the model
	logic                 pin;          // Crossover strap pin
	logic                 eep_present;  // Loader attached
	logic                 eep_valid;    // Loader pulse
	pss_pkg::pss_straps_t eep_straps;   // Loader payload
	logic                 psel;         // APB select
	logic                 penable;      // APB enable
	logic                 pwrite;       // APB direction
	logic [7:0]           paddr;        // APB address
	logic [31:0]          pwdata;       // APB write data
	logic [31:0]          prdata;       // APB read data
	logic                 pready;       // APB ready
	logic                 pslverr;      // APB error
	pss_pkg::pss_regs_t   cfg;          // Port configuration
	pss_pkg::pss_xover_t  xov;          // Resolved crossover
	int                   n_fail;       // Mismatches
	int                   n_tests;      // Comparisons
	int                   cyc;          // Timeout counter
	pss_pkg::pss_straps_t ts;           // Tie-off straps, pin high
	pss_pkg::pss_straps_t ls;           // Loader payload one
	pss_pkg::pss_straps_t ls2;          // Loader payload two

	//****************************************************************
	// Instances
	//****************************************************************
	pss_strap_loader u_pss_strap_loader (
		.CORE_CLK(clk), .RST_N(rst_n), .P1_CROSSOVER_INDICATOR_PIN(pin),
		.EEP_PRESENT(eep_present), .EEP_OVR_VALID(eep_valid), .EEP_OVR_STRAPS(eep_straps),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .P1_CFG(cfg), .P1_XOVER(xov)
	);
	pss_strap_model u_pss_strap_model (
		.clk(clk), .rst_n(rst_n), .pin(pin), .eep_present(eep_present),
		.eep_valid(eep_valid), .eep_straps(eep_straps)
	);

	//****************************************************************
	// Clock and timeout
	//****************************************************************
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end

	// Cuts a hang short
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			wrap_up();
		end
	end

	//****************************************************************
	// Tasks
	//****************************************************************
	// Final report
	task automatic wrap_up();
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Word compare
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// Configuration struct compare
	task automatic chk_cfg(input pss_pkg::pss_regs_t got, input pss_pkg::pss_regs_t exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t cfg got %h exp %h", $time, got, exp);
		end
	endtask

	// Crossover struct compare
	task automatic chk_xov(input pss_pkg::pss_xover_t got, input pss_pkg::pss_xover_t exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t xover got %h exp %h", $time, got, exp);
		end
	endtask

	// One APB transfer: setup, access until ready
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd_d, output logic er);
		@(posedge clk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clk);
		penable <= 1'h1;
		// Waits for ready with no limit of its own; the bench timeout ends a hang
		do begin
			@(posedge clk);
		end while (pready !== 1'h1);
		rd_d = prdata;
		er   = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask

	// Write, ignoring the answer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'h1, a, d, r, e);
	endtask

	// Read and compare data and error flag
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic ee);
		logic [31:0] r;
		logic        e;
		apb(1'h0, a, 32'h0, r, e);
		chk32(r, exp, "read data");
		chk32({31'h0, e}, {31'h0, ee}, "error flag");
	endtask

	// Expected configuration from a strap set
	function automatic pss_pkg::pss_regs_t exp_cfg(input pss_pkg::pss_straps_t s);
		pss_pkg::pss_regs_t r;
		r           = '0;
		r.ind_en    = s.ind_en;
		r.ind_fun   = s.ind_fun;
		r.xsel      = 1'h1;
		r.sw_auto_x = 1'h1;
		r.an_en     = s.autoneg;
		r.speed_lsb = s.autoneg | s.speed;
		r.duplex    = s.autoneg | s.duplex;
		r.adv_10hd  = s.autoneg | ~s.speed;
		r.adv_10fd  = s.autoneg | (~s.speed & s.duplex);
		r.adv_asym  = s.fdfc;
		r.mode      = s.autoneg ? 3'h7 : {1'h0, s.speed, s.duplex};
		r.bp_en     = s.bp;
		r.tx_pause  = s.fdfc;
		r.rx_pause  = s.fdfc;
		return r;
	endfunction

	// Check ports and every register but the reset control against a strap set
	task automatic chk_all(input pss_pkg::pss_straps_t s, input logic used);
		pss_pkg::pss_regs_t  e;
		pss_pkg::pss_xover_t x;
		e         = exp_cfg(s);
		x.auto_en = s.auto_x;
		x.crossed = ~s.auto_x & s.manual_x;
		chk_cfg(cfg, e);
		chk_xov(xov, x);
		rd(8'h00, {22'h0, e.ind_fun, 2'h0, e.ind_en}, 1'h0);
		rd(8'h04, {30'h0, used, s.auto_x}, 1'h0);
		rd(8'h08, {27'h0, x.crossed, x.auto_en, 3'h3}, 1'h0);
		rd(8'h0c, {18'h0, e.speed_lsb, e.an_en, 3'h0, e.duplex, 8'h0}, 1'h0);
		rd(8'h10, {20'h0, e.adv_asym, 4'h0, e.adv_10fd, e.adv_10hd, 5'h0}, 1'h0);
		rd(8'h14, {24'h0, e.mode, 5'h0}, 1'h0);
		rd(8'h18, {29'h0, e.bp_en, e.tx_pause, e.rx_pause}, 1'h0);
	endtask

	//****************************************************************
	// Main sequence
	//****************************************************************
	initial begin
		psel    = 1'h0;
		penable = 1'h0;
		pwrite  = 1'h0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
		n_fail  = 0;
		n_tests = 0;
		cyc     = 0;
		ts  = '{ind_en: 6'h3f, ind_fun: 2'h0, auto_x: 1'h1, manual_x: 1'h0,
			autoneg: 1'h1, speed: 1'h1, duplex: 1'h1, bp: 1'h1, fdfc: 1'h1};
		ls  = '{ind_en: 6'h15, ind_fun: 2'h2, auto_x: 1'h0, manual_x: 1'h1,
			autoneg: 1'h0, speed: 1'h0, duplex: 1'h1, bp: 1'h0, fdfc: 1'h0};
		ls2 = '{ind_en: 6'h2a, ind_fun: 2'h1, auto_x: 1'h1, manual_x: 1'h1,
			autoneg: 1'h0, speed: 1'h1, duplex: 1'h0, bp: 1'h1, fdfc: 1'h0};
		// Power-on with pin high: tie-off defaults
		u_pss_strap_model.pin_reset(1'h1, 20);
		repeat (3) @(posedge clk);
		chk_all(ts, 1'h0);
		// Unmapped address and read-only strap state
		rd(8'h20, 32'h0, 1'h1);
		wr(8'h04, 32'h0);
		rd(8'h04, 32'h1, 1'h0);
		// Software write sticks, latch untouched
		wr(8'h0c, 32'h0);
		rd(8'h0c, 32'h0, 1'h0);
		// Software crossover select: straps ignored, crossed wiring
		wr(8'h08, 32'h4);
		rd(8'h08, 32'h14, 1'h0);
		chk_xov(xov, 2'h1);
		// Loader overrides every strap
		u_pss_strap_model.load(ls);
		repeat (3) @(posedge clk);
		chk_all(ls, 1'h1);
		// Digital reset without loader: latched values, pin ignored
		u_pss_strap_model.set_lines(1'h0, 1'h0);
		wr(8'h1c, 32'h1);
		repeat (3) @(posedge clk);
		chk_all(ts, 1'h0);
		// Reload with loader: pending until its delivery
		u_pss_strap_model.set_lines(1'h0, 1'h1);
		wr(8'h1c, 32'h2);
		rd(8'h1c, 32'h4, 1'h0);
		u_pss_strap_model.load(ls2);
		repeat (3) @(posedge clk);
		rd(8'h1c, 32'h0, 1'h0);
		chk_all(ls2, 1'h1);
		// New pin reset with pin low re-latches the pin
		u_pss_strap_model.set_lines(1'h0, 1'h0);
		u_pss_strap_model.pin_reset(1'h0, 20);
		repeat (3) @(posedge clk);
		ts.auto_x = 1'h0;
		chk_all(ts, 1'h0);
		wrap_up();
	end
endmodule
`default_nettype wire
